// file: rtl/gsc_pkg.sv
// package: constants for the guest state cache and tagged tlb
package gsc_pkg;
	localparam int          GSC_TAG_W        = 8;
	localparam int          GSC_ADDR_W       = 40;
	localparam int          GSC_GRP_N        = 11;
	localparam logic [11:0] GSC_CLEAN_OFS    = 12'h0C0;
	localparam logic [31:0] GSC_CLEAN_ALL    = 32'hFFFF_FFFF;
	localparam logic [31:0] GSC_CLEAN_NONE   = 32'h0000_0000;
	localparam logic [31:0] GSC_CLEAN_VALID  = 32'h0000_07FF;
	// clean bit positions
	localparam int GSC_B_INTERCEPT  = 0;
	localparam int GSC_B_PERM_MAP   = 1;
	localparam int GSC_B_TAG        = 2;
	localparam int GSC_B_VIRT_INT   = 3;
	localparam int GSC_B_NESTED     = 4;
	localparam int GSC_B_CTRL_REG   = 5;
	localparam int GSC_B_DEBUG      = 6;
	localparam int GSC_B_DESC_TBL   = 7;
	localparam int GSC_B_SEGMENT    = 8;
	localparam int GSC_B_FAULT_ADDR = 9;
	localparam int GSC_B_BRANCH     = 10;
	// flush command encodings (low three bits of the command byte)
	localparam logic [2:0] GSC_FL_NONE     = 3'h0;
	localparam logic [2:0] GSC_FL_ALL      = 3'h1;
	localparam logic [2:0] GSC_FL_GUEST    = 3'h3;
	localparam logic [2:0] GSC_FL_GUEST_NG = 3'h7;
	localparam logic [GSC_TAG_W-1:0] GSC_HOST_TAG = 8'h00;
	typedef enum logic [1:0]
	{
		GSC_ST_IDLE  = 2'b00,
		GSC_ST_FLUSH = 2'b01,
		GSC_ST_RUN   = 2'b10
	} gsc_state_t;
endpackage

// file: rtl/gsc_tlb.sv
// tagged translation lookaside buffer with selective flush
`timescale 1ns/1ps
module gsc_tlb
	import gsc_pkg::*;
#(
	parameter int ENTRIES = 8,
	parameter int VA_W    = 20,
	parameter int PA_W    = 28
)
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  fill_vld,
	input  wire logic [GSC_TAG_W-1:0]  fill_tag,
	input  wire logic [VA_W-1:0]       fill_va,
	input  wire logic [PA_W-1:0]       fill_pa,
	input  wire logic                  fill_glb,
	input  wire logic                  fl_all,
	input  wire logic                  fl_tag,
	input  wire logic                  fl_tag_ng,
	input  wire logic [GSC_TAG_W-1:0]  fl_sel,
	input  wire logic [GSC_TAG_W-1:0]  lk_tag,
	input  wire logic [VA_W-1:0]       lk_va,
	output logic                       lk_hit,
	output logic [PA_W-1:0]            lk_pa
);
	localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
	logic [ENTRIES-1:0]   vld_r;
	logic [ENTRIES-1:0]   glb_r;
	logic [GSC_TAG_W-1:0] tag_r [ENTRIES];
	logic [VA_W-1:0]      va_r  [ENTRIES];
	logic [PA_W-1:0]      pa_r  [ENTRIES];
	logic [IW-1:0]        vic_r;
	logic [ENTRIES-1:0]   hit_w;
	logic [ENTRIES-1:0]   kill_w;
	logic [ENTRIES-1:0]   xtag_w;
	logic                 wr_w;

	// match needs the same tag even for global entries
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++)
		begin : g_ent
			assign hit_w[g]  = vld_r[g] && tag_r[g] == lk_tag && va_r[g] == lk_va;
			assign kill_w[g] = fl_all || (tag_r[g] == fl_sel && (fl_tag || (fl_tag_ng && !glb_r[g])));
			// a global entry under a foreign tag must never count as a hit
			assign xtag_w[g] = vld_r[g] && glb_r[g] && tag_r[g] != lk_tag && va_r[g] == lk_va;
		end
	endgenerate

	// priority read of the first hit
	always_comb
	begin
		lk_hit = |hit_w;
		lk_pa  = '0;
		for (int i = ENTRIES - 1; i >= 0; i--)
			if (hit_w[i])
				lk_pa = pa_r[i];
	end

	// a full flush wins over a fill in the same cycle; a tag flush does not, the fill still sets its entry valid
	assign wr_w = fill_vld && !fl_all;

	// round robin fill of the valid and global bits
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			vld_r <= '0;
			glb_r <= '0;
			vic_r <= '0;
		end
		else
		begin
			vld_r <= vld_r & ~kill_w;
			if (wr_w)
			begin
				vld_r[vic_r] <= 1'b1;
				glb_r[vic_r] <= fill_glb;
				vic_r        <= (vic_r == IW'(ENTRIES - 1)) ? '0 : vic_r + 1'b1;
			end
		end
	end

	// payload needs no reset; the valid bit guards it
	always_ff @(posedge clk_sys)
	begin
		if (wr_w)
		begin
			tag_r[vic_r] <= fill_tag;
			va_r[vic_r]  <= fill_va;
			pa_r[vic_r]  <= fill_pa;
		end
	end

	a_flush_all_empties : assert property (@(posedge clk_sys) disable iff (rst)
		fl_all |=> vld_r == '0) else $error("entries survive a full flush");
	a_tag_isolation : assert property (@(posedge clk_sys) disable iff (rst)
		(hit_w & xtag_w) == '0) else $error("global entry hit under foreign tag");
endmodule // gsc_tlb

// file: rtl/gsc_top.sv
// guest state cache with tagged tlb flush control
`timescale 1ns/1ps
module gsc_top
	import gsc_pkg::*;
#(
	parameter int SLOTS = 4,
	parameter int ENTRIES = 8,
	parameter int VA_W = 20,
	parameter int PA_W = 28,
	parameter bit HAS_OPT_FLUSH = 1'b1
)
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// guest entry request with fields read from the control block
	input  wire logic                   entry_req,
	input  wire logic [GSC_ADDR_W-1:0]  entry_blk_addr,
	input  wire logic [31:0]            guest_state_clean_mask,
	input  wire logic [7:0]             tlb_flush_command,
	input  wire logic [GSC_TAG_W-1:0]   entry_tag,
	// guest exit, saving state into the cache
	input  wire logic                   exit_evt,
	// architectural tlb events
	input  wire logic                   sys_mgmt_interrupt,
	input  wire logic                   sys_mgmt_return,
	input  wire logic                   xlat_msr_write,
	input  wire logic                   paging_ctl_change,
	input  wire logic                   flush_intercepted,
	// translation fill and lookup
	input  wire logic                   fill_vld,
	input  wire logic [VA_W-1:0]        fill_va,
	input  wire logic [PA_W-1:0]        fill_pa,
	input  wire logic                   fill_glb,
	input  wire logic [VA_W-1:0]        lk_va,
	output logic                        lk_hit_r,
	output logic [PA_W-1:0]             lk_pa_r,
	// entry outcome, guest state and flush capabilities
	output logic                        entry_done_r,
	output logic [31:0]                 grp_from_cache_r,
	output logic [31:0]                 grp_from_mem_r,
	output logic                        in_guest_r,
	output logic [GSC_TAG_W-1:0]        cur_tag_r,
	output logic [2:0]                  flush_caps_r
);
	localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

	// ****************************************************************
	// state cache bookkeeping
	// ****************************************************************
	gsc_state_t               st_r;
	gsc_state_t               st_nxt;
	logic [GSC_ADDR_W-1:0]    slot_addr_r [SLOTS];
	logic [SLOTS-1:0]         slot_vld_r;
	logic [SW-1:0]            slot_cur_r;
	logic [SW-1:0]            slot_rep_r;
	logic                     smi_seen_r;
	logic [GSC_ADDR_W-1:0]    blk_addr_r;
	logic [SLOTS-1:0]         slot_hit_w;
	logic                     any_hit_w;
	logic [SW-1:0]            hit_idx_w;
	logic [31:0]              eff_clean_w;
	logic [2:0]               fl_code_w;
	logic                     fl_all_w;
	logic                     fl_tag_w;
	logic                     fl_tag_ng_w;
	logic [GSC_TAG_W-1:0]     fl_sel_w;
	logic                     lk_hit_w;
	logic [PA_W-1:0]          lk_pa_w;

	// ownership by block physical address only, the tag never enters the compare
	genvar g;
	generate
		for (g = 0; g < SLOTS; g++)
		begin : g_slot
			assign slot_hit_w[g] = slot_vld_r[g] && slot_addr_r[g] == entry_blk_addr;
		end
	endgenerate

	// encoder for the matching slot
	always_comb
	begin
		hit_idx_w = '0;
		for (int i = SLOTS - 1; i >= 0; i--)
			if (slot_hit_w[i])
				hit_idx_w = SW'(i);
	end

	assign any_hit_w = |slot_hit_w;

	// effective mask: miss or pending interrupt forces every group from memory;
	// reserved bits are dropped so they never claim a cached group
	assign eff_clean_w = (any_hit_w && !smi_seen_r)
		? (guest_state_clean_mask & GSC_CLEAN_VALID)
		: GSC_CLEAN_NONE;

	// ****************************************************************
	// flush command decode
	// ****************************************************************
	// the command byte is an input only; nothing here can write it back
	assign fl_code_w = tlb_flush_command[2:0];

	// entry flushes, event flushes; entry/exit register loads flush nothing
	assign fl_all_w = (entry_req && st_r == GSC_ST_IDLE && fl_code_w == GSC_FL_ALL)
		|| sys_mgmt_interrupt || sys_mgmt_return || xlat_msr_write;
	assign fl_tag_w = (entry_req && st_r == GSC_ST_IDLE && fl_code_w == GSC_FL_GUEST)
		|| (paging_ctl_change && !flush_intercepted);
	assign fl_tag_ng_w = HAS_OPT_FLUSH && entry_req && st_r == GSC_ST_IDLE
		&& fl_code_w == GSC_FL_GUEST_NG;
	// flushes in an entry cycle use the incoming guest tag, flushes in other cycles the current one
	assign fl_sel_w = (entry_req && st_r == GSC_ST_IDLE) ? entry_tag : cur_tag_r;

	gsc_tlb #(
		.ENTRIES (ENTRIES),
		.VA_W    (VA_W),
		.PA_W    (PA_W)
	) u_tlb (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.fill_vld  (fill_vld),
		.fill_tag  (cur_tag_r),
		.fill_va   (fill_va),
		.fill_pa   (fill_pa),
		.fill_glb  (fill_glb),
		.fl_all    (fl_all_w),
		.fl_tag    (fl_tag_w),
		.fl_tag_ng (fl_tag_ng_w),
		.fl_sel    (fl_sel_w),
		.lk_tag    (cur_tag_r),
		.lk_va     (lk_va),
		.lk_hit    (lk_hit_w),
		.lk_pa     (lk_pa_w)
	);

	// ****************************************************************
	// guest context sequencing
	// ****************************************************************
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			GSC_ST_IDLE:
				if (entry_req)
					st_nxt = GSC_ST_RUN;
			GSC_ST_RUN:
				if (exit_evt || flush_intercepted)
					st_nxt = GSC_ST_IDLE;
			GSC_ST_FLUSH:
				st_nxt = GSC_ST_IDLE;
			default:
				st_nxt = GSC_ST_IDLE;
		endcase
	end

	// state register and guest tag
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_r       <= GSC_ST_IDLE;
			in_guest_r <= 1'b0;
			cur_tag_r  <= GSC_HOST_TAG;
		end
		else
		begin
			st_r       <= st_nxt;
			in_guest_r <= (st_nxt == GSC_ST_RUN);
			cur_tag_r  <= (st_nxt == GSC_ST_RUN) ? ((st_r == GSC_ST_IDLE) ? entry_tag : cur_tag_r)
				: GSC_HOST_TAG;
		end
	end

	// interrupt seen flag: a new interrupt in the entry cycle wins over the clear
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			smi_seen_r <= 1'b1;
		else if (sys_mgmt_interrupt)
			smi_seen_r <= 1'b1;
		else if (entry_req && st_r == GSC_ST_IDLE)
			smi_seen_r <= 1'b0;
	end

	// entry outcome; uncached fields are not in the mask and always load
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			entry_done_r     <= 1'b0;
			grp_from_cache_r <= GSC_CLEAN_NONE;
			grp_from_mem_r   <= GSC_CLEAN_NONE;
		end
		else
		begin
			entry_done_r <= entry_req && st_r == GSC_ST_IDLE;
			if (entry_req && st_r == GSC_ST_IDLE)
			begin
				grp_from_cache_r <= eff_clean_w;
				grp_from_mem_r   <= ~eff_clean_w & GSC_CLEAN_VALID;
			end
		end
	end

	// slot tracking: exit refreshes the running block's slot, miss claims a victim
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			slot_vld_r <= '0;
			slot_cur_r <= '0;
			slot_rep_r <= '0;
			blk_addr_r <= '0;
		end
		else
		begin
			if (entry_req && st_r == GSC_ST_IDLE)
			begin
				blk_addr_r <= entry_blk_addr;
				slot_cur_r <= any_hit_w ? hit_idx_w : slot_rep_r;
				if (!any_hit_w)
					slot_vld_r[slot_rep_r] <= 1'b0;
			end
			if (st_r == GSC_ST_RUN && exit_evt)
			begin
				slot_vld_r[slot_cur_r]  <= 1'b1;
				if (slot_cur_r == slot_rep_r)
					slot_rep_r <= (slot_rep_r == SW'(SLOTS - 1)) ? '0 : slot_rep_r + 1'b1;
			end
			if (sys_mgmt_interrupt)
				slot_vld_r <= '0;
		end
	end

	// stored block address needs no reset; the slot valid bit guards it
	always_ff @(posedge clk_sys)
	begin
		if (st_r == GSC_ST_RUN && exit_evt)
			slot_addr_r[slot_cur_r] <= blk_addr_r;
	end

	// registered lookup result and capability report
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			lk_hit_r     <= 1'b0;
			lk_pa_r      <= '0;
			flush_caps_r <= 3'h0;
		end
		else
		begin
			lk_hit_r     <= lk_hit_w;
			lk_pa_r      <= lk_pa_w;
			flush_caps_r <= {HAS_OPT_FLUSH, 2'b11};
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_miss_zero_mask : assert property (@(posedge clk_sys) disable iff (rst)
		(entry_req && st_r == GSC_ST_IDLE && !any_hit_w) |=> grp_from_cache_r == '0)
		else $error("cache used on address miss");
	a_smi_zero_mask : assert property (@(posedge clk_sys) disable iff (rst)
		(entry_req && st_r == GSC_ST_IDLE && smi_seen_r) |=> grp_from_cache_r == '0)
		else $error("cache used after interrupt");
	a_clear_bit_load : assert property (@(posedge clk_sys) disable iff (rst)
		entry_done_r |-> (grp_from_cache_r & grp_from_mem_r) == '0)
		else $error("group both cached and loaded");
	a_clean_honoured : assert property (@(posedge clk_sys) disable iff (rst)
		(entry_req && st_r == GSC_ST_IDLE)
			|=> (grp_from_cache_r & ~$past(guest_state_clean_mask)) == '0)
		else $error("clear bit served from cache");
	a_reserved_ignored : assert property (@(posedge clk_sys) disable iff (rst)
		entry_done_r |-> grp_from_cache_r[31:GSC_GRP_N] == '0)
		else $error("reserved clean bit used");
	a_host_tag_zero : assert property (@(posedge clk_sys) disable iff (rst)
		!in_guest_r |-> cur_tag_r == GSC_HOST_TAG)
		else $error("nonzero tag outside guest");
	a_no_entry_flush : assert property (@(posedge clk_sys) disable iff (rst)
		(entry_req && fl_code_w == GSC_FL_NONE && !sys_mgmt_interrupt && !sys_mgmt_return
			&& !xlat_msr_write && !paging_ctl_change) |-> !fl_all_w && !fl_tag_w && !fl_tag_ng_w)
		else $error("flush without command");
	a_smi_flushes_all : assert property (@(posedge clk_sys) disable iff (rst)
		(sys_mgmt_interrupt || sys_mgmt_return) |-> fl_all_w)
		else $error("interrupt did not flush all");
	a_intercept_no_flush : assert property (@(posedge clk_sys) disable iff (rst)
		(flush_intercepted && !entry_req) |-> !fl_tag_w)
		else $error("intercepted action flushed");
	c_hit_entry : cover property (@(posedge clk_sys) entry_done_r && grp_from_cache_r != '0);
	c_exit_after_run : cover property (@(posedge clk_sys) st_r == GSC_ST_RUN ##1 st_r == GSC_ST_IDLE);
	c_full_flush : cover property (@(posedge clk_sys) fl_all_w);
	c_tag_ng_flush : cover property (@(posedge clk_sys) fl_tag_ng_w);
endmodule // gsc_top

// file: verif/guest_state_cache_tlb_flush_test.sv
// self-checking bench for the guest state cache and tagged tlb
`timescale 1ns/1ps
module guest_state_cache_tlb_flush_test;
	import gsc_pkg::*;
	localparam logic [39:0] ADR_A = 40'h00_1234_5000;
	localparam logic [39:0] ADR_B = 40'h00_0ABC_D000;
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	logic                  entry_req = 1'b0;
	logic [GSC_ADDR_W-1:0] entry_blk_addr = '0;
	logic [31:0]           guest_state_clean_mask = '0;
	logic [7:0]            tlb_flush_command = '0;
	logic [GSC_TAG_W-1:0]  entry_tag = '0;
	logic                  exit_evt = 1'b0;
	logic [4:0]            ev_bus = '0;
	logic                  fill_vld = 1'b0;
	logic [19:0]           fill_va = '0;
	logic [27:0]           fill_pa = '0;
	logic                  fill_glb = 1'b0;
	logic [19:0]           lk_va = '0;
	logic                  lk_hit_r;
	logic [27:0]           lk_pa_r;
	logic                  entry_done_r;
	logic [31:0]           grp_from_cache_r;
	logic [31:0]           grp_from_mem_r;
	logic                  in_guest_r;
	logic [7:0]            cur_tag_r;
	logic [2:0]            flush_caps_r;
	int                    bad_count = 0;
	int                    samples_checked = 0;

	// ****************************************
	// clock and device
	// ****************************************
	always #2 clk_sys = ~clk_sys;

	gsc_top dut_u (
		.clk_sys(clk_sys), .rst(rst), .entry_req(entry_req), .entry_blk_addr(entry_blk_addr),
		.guest_state_clean_mask(guest_state_clean_mask), .tlb_flush_command(tlb_flush_command),
		.entry_tag(entry_tag), .exit_evt(exit_evt), .sys_mgmt_interrupt(ev_bus[0]),
		.sys_mgmt_return(ev_bus[1]), .xlat_msr_write(ev_bus[2]),
		.paging_ctl_change(ev_bus[3]), .flush_intercepted(ev_bus[4]), .fill_vld(fill_vld),
		.fill_va(fill_va), .fill_pa(fill_pa), .fill_glb(fill_glb), .lk_va(lk_va),
		.lk_hit_r(lk_hit_r), .lk_pa_r(lk_pa_r), .entry_done_r(entry_done_r),
		.grp_from_cache_r(grp_from_cache_r), .grp_from_mem_r(grp_from_mem_r),
		.in_guest_r(in_guest_r), .cur_tag_r(cur_tag_r), .flush_caps_r(flush_caps_r)
	);

	// ****************************************
	// compare and drive helpers
	// ****************************************
	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// all inputs change at the falling edge, away from the sampling edge
	task automatic enter(input logic [39:0] adr, input logic [31:0] msk, input logic [2:0] cmd,
		input logic [7:0] tag);
		entry_blk_addr = adr;
		guest_state_clean_mask = msk;
		tlb_flush_command = {5'h00, cmd};
		entry_tag = tag;
		entry_req = 1'b1;
		@(negedge clk_sys);
		entry_req = 1'b0;
		chk_bit(entry_done_r, 1'b1, "entry done");
		chk_word({24'h0, cur_tag_r}, {24'h0, tag}, "guest tag");
	endtask

	task automatic leave;
		exit_evt = 1'b1;
		@(negedge clk_sys);
		exit_evt = 1'b0;
		chk_bit(in_guest_r, 1'b0, "exit");
		chk_word({24'h0, cur_tag_r}, 32'h0, "host tag");
	endtask

	task automatic masks(input logic [10:0] c);
		chk_word(grp_from_cache_r, {21'h0, c}, "cached groups");
		chk_word(grp_from_mem_r, {21'h0, ~c}, "loaded groups");
	endtask

	// pa is derived from va so expectations need no table
	task automatic fill(input logic [19:0] va, input logic glb);
		fill_va = va;
		fill_pa = {8'hA5, va};
		fill_glb = glb;
		fill_vld = 1'b1;
		@(negedge clk_sys);
		fill_vld = 1'b0;
	endtask

	// one spare cycle so a flush launched just before has surely landed
	task automatic look(input logic [19:0] va, input logic hit);
		lk_va = va;
		repeat (2) @(negedge clk_sys);
		chk_bit(lk_hit_r, hit, "lookup hit");
		if (hit)
			chk_word({4'h0, lk_pa_r}, {12'h0A5, va}, "lookup pa");
	endtask

	task automatic ev(input int k);
		ev_bus = 5'h00;
		ev_bus[k] = 1'b1;
		if (k == 4)
			ev_bus[3] = 1'b1;
		@(negedge clk_sys);
		ev_bus = 5'h00;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_cache;
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_NONE, 8'h05);
		masks(11'h000);
		entry_req = 1'b1;
		@(negedge clk_sys);
		entry_req = 1'b0;
		chk_bit(entry_done_r, 1'b0, "refused entry");
		leave();
		for (int i = 0; i < 11; i++)
		begin
			enter(ADR_A, 32'h1 << i, GSC_FL_NONE, 8'h05);
			masks(11'h1 << i);
			leave();
		end
		enter(ADR_A, 32'hFFFF_F800, GSC_FL_NONE, 8'h05);
		masks(11'h000);
		leave();
		enter(ADR_A, 32'hFFFF_FFFB, GSC_FL_NONE, 8'h09);
		masks(11'h7FB);
		leave();
		enter(ADR_B, GSC_CLEAN_ALL, GSC_FL_NONE, 8'h05);
		masks(11'h000);
		leave();
	endtask

	task automatic t_smi;
		fill(20'h00033, 1'b0);
		ev(0);
		look(20'h00033, 1'b0);
		enter(ADR_A, 32'hFFFF_FFFB, GSC_FL_NONE, 8'h05);
		masks(11'h000);
		leave();
		enter(ADR_A, GSC_CLEAN_ALL, GSC_FL_NONE, 8'h05);
		masks(11'h7FF);
		leave();
	endtask

	task automatic t_tags;
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_NONE, 8'h05);
		fill(20'h00011, 1'b0);
		fill(20'h00022, 1'b1);
		look(20'h00011, 1'b1);
		leave();
		look(20'h00022, 1'b0);
		fill(20'h00033, 1'b0);
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_NONE, 8'h05);
		look(20'h00011, 1'b1);
		look(20'h00033, 1'b0);
		leave();
		look(20'h00033, 1'b1);
	endtask

	task automatic t_flush;
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_GUEST_NG, 8'h05);
		look(20'h00011, 1'b0);
		look(20'h00022, 1'b1);
		leave();
		look(20'h00033, 1'b1);
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_GUEST, 8'h05);
		look(20'h00022, 1'b0);
		fill(20'h00011, 1'b1);
		leave();
		look(20'h00033, 1'b1);
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_ALL, 8'h06);
		leave();
		look(20'h00033, 1'b0);
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_NONE, 8'h05);
		look(20'h00011, 1'b0);
		leave();
	endtask

	task automatic t_events;
		fill(20'h00033, 1'b0);
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_NONE, 8'h05);
		fill(20'h00011, 1'b0);
		ev(4);
		chk_bit(in_guest_r, 1'b0, "intercept exit");
		enter(ADR_A, GSC_CLEAN_NONE, GSC_FL_NONE, 8'h05);
		look(20'h00011, 1'b1);
		ev(3);
		look(20'h00011, 1'b0);
		leave();
		look(20'h00033, 1'b1);
		for (int k = 1; k < 3; k++)
		begin
			fill(20'h00044, 1'b1);
			ev(k);
			look(20'h00044, 1'b0);
		end
	endtask

	// ****************************************
	// sequence, watchdog and verdict
	// ****************************************
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// whole run is well under a thousand cycles; five thousand is ample
	initial
	begin
		#20000;
		bad_count++;
		close_out();
	end

	initial
	begin
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		chk_word({29'h0, flush_caps_r}, 32'h7, "capabilities");
		chk_bit(in_guest_r, 1'b0, "idle after reset");
		t_cache();
		t_smi();
		t_tags();
		t_flush();
		t_events();
		close_out();
	end
endmodule // guest_state_cache_tlb_flush_test
